// ===== bench/rchx_core_asserts.sv
`timescale 1ns/10ps
module rchx_core_asserts #(
	parameter int WDOG_W = 8,
	parameter int PRE_W  = 8
) (
	// clock
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        ce,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// power
	input wire logic        osc_run,
	input wire logic        sleeping
);
	logic [2:0] bcnt_r;
	logic [2:0] bcnt_nxt;
	logic       wr;
	logic       rs;
	logic       acc;
	logic       halt;
	assign wr = psel && penable && pwrite && ce;
	assign rs = psel && !penable && !pwrite && ce;
	assign acc = wr && paddr == 12'h000 && bcnt_r == 3'h0 && !sleeping;
	assign halt = acc && pwdata[13:0] == 14'h0183;
	// mirrors the busy window of an accepted instruction
	always_comb begin
		bcnt_nxt = bcnt_r;
		if (ce && bcnt_r != 3'h0)
			bcnt_nxt = bcnt_r - 3'h1;
		else if (acc)
			bcnt_nxt = 3'h4;
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bcnt_r <= 3'h0;
		else
			bcnt_r <= bcnt_nxt;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_osc_off; sleeping |-> !osc_run; endproperty
	a_osc_off: assert property (p_osc_off) else $error("osc runs in sleep");
	property p_sleep_hold; sleeping && !(wr && paddr == 12'h010 && pwdata[0]) |=> sleeping;
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep left");
	property p_halt_q13; halt |=> (!sleeping && osc_run)[*4]; endproperty
	a_halt_q13: assert property (p_halt_q13) else $error("early sleep");
	property p_halt_q4; halt ##1 ce[*4] |=> sleeping && !osc_run; endproperty
	a_halt_q4: assert property (p_halt_q4) else $error("no sleep");
	property p_nop_awake; acc && pwdata[13:0] != 14'h0183 ##1 ce[*4] |=> !sleeping; endproperty
	a_nop_awake: assert property (p_nop_awake) else $error("bad sleep");
	property p_st_pd; rs && paddr == 12'h008 && sleeping |=> !prdata[1]; endproperty
	a_st_pd: assert property (p_st_pd) else $error("pd flag");
	property p_st_to; rs && paddr == 12'h008 && sleeping |=> prdata[2]; endproperty
	a_st_to: assert property (p_st_to) else $error("to flag");
	property p_wd_clr;
		rs && paddr == 12'h00c && sleeping |=>
			prdata[WDOG_W-1:0] == '0 && prdata[8+:PRE_W] == '0;
	endproperty
	a_wd_clr: assert property (p_wd_clr) else $error("wdog not clear");
endmodule

bind rchx_core rchx_core_asserts #(.WDOG_W(WDOG_W), .PRE_W(PRE_W)) chk_u (
	.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .osc_run(osc_run), .sleeping(sleeping)
);

// ===== bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
	logic        pclk;
	logic        presetn;
	logic        ce;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        osc_run;
	logic        sleeping;
	logic [31:0] rdat;
	logic        rerr;
	logic [7:0]  v;
	logic [7:0]  res;
	logic        c;
	logic        cout;
	logic [6:0]  f;
	logic [11:0] ma;
	logic [13:0] iw;
	logic [13:0] nops [3] = '{14'h0182, 14'h0e05, 14'h1d05};
	int          fails;
	int          cmp_count;

	rchx_core #(.WDOG_W(8), .PRE_W(8)) dut_u (
		.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .osc_run(osc_run), .sleeping(sleeping)
	);

	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			fails++;
			$display("[ERR] %0t no pready", $time);
		end
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask

	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			xfer(1'b0, 12'h008, 32'h0);
			n++;
		end while (rdat[4] !== 1'b0 && n < 10);
		if (rdat[4] !== 1'b0) begin
			fails++;
			$display("[ERR] %0t still busy", $time);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#400000;
		fails++;
		$display("[ERR] %0t timeout", $time);
		summarize();
	end

	initial begin
		fails = 0;
		cmp_count = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h004, 32'h0);
		rd(12'h008, 32'h6);
		rd(12'h100, 32'h0);
		chk(32'(rerr), 32'h1);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			f = (i == 7) ? 7'h7f : 7'(i * 17);
			v = 8'he6 + 8'(i * 37);
			c = i[2];
			ma = 12'h200 + {3'h0, f, 2'b00};
			xfer(1'b1, ma, 32'(v));
			xfer(1'b1, 12'h004, 32'h5a);
			xfer(1'b1, 12'h008, 32'(c));
			iw = {i[0] ? 6'h0d : 6'h0c, i[1], f};
			xfer(1'b1, 12'h000, 32'(iw));
			// second word lands while busy and must be dropped
			xfer(1'b1, 12'h000, 32'(iw));
			wait_idle();
			res = i[0] ? {v[6:0], c} : {c, v[7:1]};
			cout = i[0] ? v[7] : v[0];
			rd(12'h004, i[1] ? 32'h5a : 32'(res));
			rd(ma, 32'(i[1] ? res : v));
			rd(12'h008, {27'h0, 4'h3, cout});
		end
		$display("test rotate done");
		for (int k = 0; k < 3; k++) begin
			xfer(1'b1, 12'h000, 32'(nops[k]));
			wait_idle();
			chk(32'(sleeping), 32'h0);
			rd(12'h004, 32'h5a);
		end
		ce <= 1'b0;
		xfer(1'b1, 12'h004, 32'h11);
		ce <= 1'b1;
		rd(12'h004, 32'h5a);
		$display("test decode done");
		xfer(1'b0, 12'h00c, 32'h0);
		chk(32'(rdat[15:0] != 16'h0), 32'h1);
		xfer(1'b1, 12'h000, 32'h183);
		for (int k = 0; k < 20 && sleeping !== 1'b1; k++)
			@(posedge pclk);
		chk(32'(osc_run), 32'h0);
		xfer(1'b0, 12'h008, 32'h0);
		chk(32'(rdat[3:1]), 32'h6);
		repeat (20) @(posedge pclk);
		rd(12'h00c, 32'h0);
		xfer(1'b1, 12'h000, 32'h0d00);
		repeat (8) @(posedge pclk);
		rd(12'h004, 32'h5a);
		xfer(1'b1, 12'h010, 32'h1);
		chk(32'(sleeping), 32'h0);
		$display("test halt done");
		summarize();
	end
endmodule

// ===== design/rchx_alu.sv
`timescale 1ns/10ps
`include "rchx_map.svh"

module rchx_alu (
	rchx_alu_if.alu a
);

	function automatic rchx_pkg::rchx_op_t decode_op(input logic [13:0] ins);
		if (ins == `RCHX_HALT_CODE) begin
			decode_op = rchx_pkg::OP_HALT;
		end else if (ins[`RCHX_PREFIX_MSB:`RCHX_PREFIX_LSB] == `RCHX_RLC_PREFIX) begin
			decode_op = rchx_pkg::OP_RLC;
		end else if (ins[`RCHX_PREFIX_MSB:`RCHX_PREFIX_LSB] == `RCHX_RRC_PREFIX) begin
			decode_op = rchx_pkg::OP_RRC;
		end else begin
			decode_op = rchx_pkg::OP_NONE;
		end
	endfunction

	always_comb begin
		a.op        = decode_op(a.instr);
		a.dest_file = a.instr[`RCHX_DEST_BIT];
		a.loc       = a.instr[6:0];
		case (a.op)
			rchx_pkg::OP_RLC: begin
				a.result    = {a.opnd[6:0], a.carry_in};
				a.carry_out = a.opnd[7];
			end
			rchx_pkg::OP_RRC: begin
				a.result    = {a.carry_in, a.opnd[7:1]};
				a.carry_out = a.opnd[0];
			end
			default: begin
				a.result    = a.opnd;
				a.carry_out = a.carry_in;
			end
		endcase
	end

endmodule

// ===== design/rchx_core.sv
// The APB register port and the register addresses were decided locally.
`timescale 1ns/10ps
`include "rchx_map.svh"

// Summary of operation
// - prefix 001101 is rotate_left_carry; carry enters bit 0, bit 7 enters carry.
// - prefix 001100 is rotate_right_carry; carry enters bit 7, bit 0 enters carry.
// - destination bit 0 writes accumulator; 1 writes back to operand location.
// - rotates take one word, one cycle: decode, read, process, write in Q1-Q4.
// - fixed pattern 0000 0110 00 0011 is halt_instr, no operands.
// - halt_instr clears sleep_entered_n to 0.
// - halt_instr sets expiry_flag_n to 1.
// - halt_instr clears watchdog_count to 00h and the watchdog prescaler.
// - after halt_instr the oscillator stops; no fetches until wake-up.
// - halt_instr decodes in Q1, idles Q2 and Q3, sleeps in Q4.
module rchx_core #(
	parameter int WDOG_W = 8,
	parameter int PRE_W  = 8
) (
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// power state
	output logic             osc_run,
	output logic             sleeping
);

	rchx_alu_if alu_bus ();

	rchx_alu u_alu (
		.a (alu_bus.alu)
	);

	// state
	rchx_pkg::rchx_phase_t phase_r;
	rchx_pkg::rchx_phase_t phase_nxt;
	logic [13:0]           instr_r;
	logic [13:0]           instr_nxt;
	rchx_pkg::rchx_op_t    op_r;
	rchx_pkg::rchx_op_t    op_nxt;
	logic [7:0]            opnd_r;
	logic [7:0]            opnd_nxt;
	logic [7:0]            res_r;
	logic [7:0]            res_nxt;
	logic                  cres_r;
	logic                  cres_nxt;
	logic [7:0]            acc_r;
	logic [7:0]            acc_nxt;
	logic                  carry_r;
	logic                  carry_nxt;
	logic                  pd_n_r;
	logic                  pd_n_nxt;
	logic                  to_n_r;
	logic                  to_n_nxt;
	logic [WDOG_W-1:0]     wdog_r;
	logic [WDOG_W-1:0]     wdog_nxt;
	logic [PRE_W-1:0]      pre_r;
	logic [PRE_W-1:0]      pre_nxt;
	logic [7:0]            mem_r   [128];
	logic [7:0]            mem_nxt [128];
	logic [31:0]           prdata_r;
	logic [31:0]           prdata_nxt;
	logic                  sleeping_r;
	logic                  sleeping_nxt;
	logic                  osc_run_r;
	logic                  osc_run_nxt;
	logic                  halt_q4;

	// bus decode
	rchx_pkg::rchx_sel_t   sel;
	logic                  acc_wr;
	logic                  setup_rd;
	logic [6:0]            bus_idx;

	function automatic rchx_pkg::rchx_sel_t reg_sel(input logic [11:0] addr);
		if (addr[11:9] == `RCHX_MEM_BASE_HI && addr[1:0] == 2'h0) begin
			reg_sel = rchx_pkg::SEL_MEM;
		end else begin
			case (addr)
				`RCHX_OFF_INSTR:  reg_sel = rchx_pkg::SEL_INSTR;
				`RCHX_OFF_ACC:    reg_sel = rchx_pkg::SEL_ACC;
				`RCHX_OFF_STATUS: reg_sel = rchx_pkg::SEL_STATUS;
				`RCHX_OFF_WDOG:   reg_sel = rchx_pkg::SEL_WDOG;
				`RCHX_OFF_WAKE:   reg_sel = rchx_pkg::SEL_WAKE;
				default:          reg_sel = rchx_pkg::SEL_NONE;
			endcase
		end
	endfunction

	function automatic logic is_rotate(input rchx_pkg::rchx_op_t op);
		is_rotate = (op == rchx_pkg::OP_RLC) || (op == rchx_pkg::OP_RRC);
	endfunction

	assign sel      = reg_sel(paddr);
	assign bus_idx  = paddr[8:2];
	assign acc_wr   = psel && penable && pwrite && ce;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && (sel == rchx_pkg::SEL_NONE);
	assign prdata   = prdata_r;
	assign sleeping = sleeping_r;
	assign osc_run  = osc_run_r;
	// the last quarter of a halt: watchdog clear and sleep entry share this edge
	assign halt_q4  = (phase_r == rchx_pkg::PH_Q4) && (op_r == rchx_pkg::OP_HALT);

	assign alu_bus.instr    = instr_r;
	assign alu_bus.opnd     = opnd_r;
	assign alu_bus.carry_in = carry_r;

	// instruction sequencer and datapath
	always_comb begin
		phase_nxt = phase_r;
		instr_nxt = instr_r;
		op_nxt    = op_r;
		opnd_nxt  = opnd_r;
		res_nxt   = res_r;
		cres_nxt  = cres_r;
		acc_nxt   = acc_r;
		carry_nxt = carry_r;
		pd_n_nxt  = pd_n_r;
		to_n_nxt  = to_n_r;
		mem_nxt   = mem_r;

		// software writes take effect at the access edge
		if (acc_wr) begin
			case (sel)
				rchx_pkg::SEL_INSTR: begin
					if (phase_r == rchx_pkg::PH_IDLE) begin
						instr_nxt = pwdata[13:0];
						phase_nxt = rchx_pkg::PH_Q1;
					end
				end
				rchx_pkg::SEL_ACC:    acc_nxt = pwdata[7:0];
				rchx_pkg::SEL_STATUS: carry_nxt = pwdata[`RCHX_ST_CARRY];
				rchx_pkg::SEL_WAKE: begin
					if (pwdata[`RCHX_WAKE_BIT] && phase_r == rchx_pkg::PH_SLEEP) begin
						phase_nxt = rchx_pkg::PH_IDLE;
					end
				end
				rchx_pkg::SEL_MEM:    mem_nxt[bus_idx] = pwdata[7:0];
				default: begin
				end
			endcase
		end

		// the instruction's own writes override any software write in the same edge
		case (phase_r)
			rchx_pkg::PH_IDLE: begin
			end
			rchx_pkg::PH_Q1: begin
				op_nxt    = alu_bus.op;
				phase_nxt = rchx_pkg::PH_Q2;
			end
			rchx_pkg::PH_Q2: begin
				if (is_rotate(op_r)) begin
					opnd_nxt = mem_r[alu_bus.loc];
				end
				phase_nxt = rchx_pkg::PH_Q3;
			end
			rchx_pkg::PH_Q3: begin
				res_nxt   = alu_bus.result;
				cres_nxt  = alu_bus.carry_out;
				phase_nxt = rchx_pkg::PH_Q4;
			end
			rchx_pkg::PH_Q4: begin
				phase_nxt = rchx_pkg::PH_IDLE;
				case (op_r)
					rchx_pkg::OP_RLC, rchx_pkg::OP_RRC: begin
						carry_nxt = cres_r;
						if (alu_bus.dest_file) begin
							mem_nxt[alu_bus.loc] = res_r;
						end else begin
							acc_nxt = res_r;
						end
					end
					rchx_pkg::OP_HALT: begin
						pd_n_nxt  = 1'b0;
						to_n_nxt  = 1'b1;
						phase_nxt = rchx_pkg::PH_SLEEP;
					end
					default: begin
					end
				endcase
			end
			rchx_pkg::PH_SLEEP: begin
			end
			default: phase_nxt = rchx_pkg::PH_IDLE;
		endcase
		// power outputs are registered copies of the next phase
		sleeping_nxt = (phase_nxt == rchx_pkg::PH_SLEEP);
		osc_run_nxt  = (phase_nxt != rchx_pkg::PH_SLEEP);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_r <= rchx_pkg::PH_IDLE;
			instr_r <= 14'h0000;
			op_r    <= rchx_pkg::OP_NONE;
			opnd_r  <= 8'h00;
			res_r   <= 8'h00;
			cres_r  <= 1'b0;
			acc_r   <= `RCHX_RST_ACC;
			carry_r <= `RCHX_RST_CARRY;
			pd_n_r  <= `RCHX_RST_PD_N;
			to_n_r  <= `RCHX_RST_TO_N;
			sleeping_r <= 1'b0;
			osc_run_r  <= 1'b1;
		end else if (ce) begin
			phase_r <= phase_nxt;
			instr_r <= instr_nxt;
			op_r    <= op_nxt;
			opnd_r  <= opnd_nxt;
			res_r   <= res_nxt;
			cres_r  <= cres_nxt;
			acc_r   <= acc_nxt;
			carry_r <= carry_nxt;
			pd_n_r  <= pd_n_nxt;
			to_n_r  <= to_n_nxt;
			sleeping_r <= sleeping_nxt;
			osc_run_r  <= osc_run_nxt;
		end
	end

	// watchdog prescaler and count; frozen in sleep, cleared as a halt leaves Q4
	always_comb begin
		pre_nxt  = pre_r;
		wdog_nxt = wdog_r;
		if (halt_q4) begin
			wdog_nxt = WDOG_W'(`RCHX_WDOG_CLEAR);
			pre_nxt  = '0;
		end else if (phase_r != rchx_pkg::PH_SLEEP) begin
			pre_nxt = pre_r + PRE_W'(1);
			if (pre_r == {PRE_W{1'b1}}) begin
				wdog_nxt = wdog_r + WDOG_W'(1);
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdog_r <= '0;
			pre_r  <= '0;
		end else if (ce) begin
			wdog_r <= wdog_nxt;
			pre_r  <= pre_nxt;
		end
	end

	generate
		for (genvar i = 0; i < 128; i++) begin : g_mem
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					mem_r[i] <= 8'h00;
				end else if (ce) begin
					mem_r[i] <= mem_nxt[i];
				end
			end
		end
	endgenerate

	// read data is captured in the setup cycle so the access phase needs no wait
	always_comb begin
		prdata_nxt = prdata_r;
		if (setup_rd) begin
			prdata_nxt = 32'h0000_0000;
			case (sel)
				rchx_pkg::SEL_INSTR:  prdata_nxt[13:0] = instr_r;
				rchx_pkg::SEL_ACC:    prdata_nxt[7:0] = acc_r;
				rchx_pkg::SEL_STATUS: begin
					prdata_nxt[`RCHX_ST_CARRY] = carry_r;
					prdata_nxt[`RCHX_ST_PD_N]  = pd_n_r;
					prdata_nxt[`RCHX_ST_TO_N]  = to_n_r;
					prdata_nxt[`RCHX_ST_SLEEP] = sleeping;
					prdata_nxt[`RCHX_ST_BUSY]  = (phase_r != rchx_pkg::PH_IDLE) && !sleeping;
				end
				rchx_pkg::SEL_WDOG: begin
					prdata_nxt[`RCHX_WD_CNT_LSB +: WDOG_W] = wdog_r;
					prdata_nxt[`RCHX_WD_PRE_LSB +: PRE_W]  = pre_r;
				end
				rchx_pkg::SEL_MEM:    prdata_nxt[7:0] = mem_r[bus_idx];
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (ce) begin
			prdata_r <= prdata_nxt;
		end
	end

endmodule

// ===== pkg/rchx_alu_if.sv
`timescale 1ns/10ps

interface rchx_alu_if;
	logic [13:0]        instr;
	logic [7:0]         opnd;
	logic               carry_in;
	rchx_pkg::rchx_op_t op;
	logic               dest_file;
	logic [6:0]         loc;
	logic [7:0]         result;
	logic               carry_out;

	modport core (
		output instr,
		output opnd,
		output carry_in,
		input  op,
		input  dest_file,
		input  loc,
		input  result,
		input  carry_out
	);

	modport alu (
		input  instr,
		input  opnd,
		input  carry_in,
		output op,
		output dest_file,
		output loc,
		output result,
		output carry_out
	);
endinterface

// ===== pkg/rchx_map.svh
`ifndef RCHX_MAP_SVH
`define RCHX_MAP_SVH

// register byte offsets on the apb bus
`define RCHX_OFF_INSTR    12'h000
`define RCHX_OFF_ACC      12'h004
`define RCHX_OFF_STATUS   12'h008
`define RCHX_OFF_WDOG     12'h00c
`define RCHX_OFF_WAKE     12'h010
// data memory window: one word per operand location
`define RCHX_MEM_BASE_HI  3'h1

// status register field positions
`define RCHX_ST_CARRY     0
`define RCHX_ST_PD_N      1
`define RCHX_ST_TO_N      2
`define RCHX_ST_SLEEP     3
`define RCHX_ST_BUSY      4

// watchdog register field positions
`define RCHX_WD_CNT_LSB   0
`define RCHX_WD_PRE_LSB   8

// wake register field position
`define RCHX_WAKE_BIT     0

// instruction encodings
`define RCHX_RLC_PREFIX   6'h0d
`define RCHX_RRC_PREFIX   6'h0c
`define RCHX_HALT_CODE    14'h0183
`define RCHX_PREFIX_MSB   13
`define RCHX_PREFIX_LSB   8
`define RCHX_DEST_BIT     7

// reset values, and the watchdog clear value loaded by halt_instr
`define RCHX_RST_ACC      8'h00
`define RCHX_RST_CARRY    1'b0
`define RCHX_RST_PD_N     1'b1
`define RCHX_RST_TO_N     1'b1
`define RCHX_WDOG_CLEAR   8'h00

`endif

// ===== pkg/rchx_pkg.sv
package rchx_pkg;

	typedef enum logic [1:0] {
		OP_NONE,
		OP_RLC,
		OP_RRC,
		OP_HALT
	} rchx_op_t;

	typedef enum logic [2:0] {
		PH_IDLE,
		PH_Q1,
		PH_Q2,
		PH_Q3,
		PH_Q4,
		PH_SLEEP
	} rchx_phase_t;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_INSTR,
		SEL_ACC,
		SEL_STATUS,
		SEL_WDOG,
		SEL_WAKE,
		SEL_MEM
	} rchx_sel_t;

endpackage
